// *** core/branch_decode_regs.vh ***
// Encoding and layout constants for the conditional branch decoder
`ifndef BRANCH_DECODE_REGS_VH
`define BRANCH_DECODE_REGS_VH
`define OP_HI 31
`define OP_LO 26
`define RS_HI 25
`define RS_LO 21
`define RT_HI 20
`define RT_LO 16
`define IMM_HI 15
`define IMM_LO 0
`define OP_REG_IMMEDIATE 6'h01
`define OP_NOT_EQUAL 6'h05
`define OP_NOT_EQUAL_LIKELY 6'h15
`define SUB_NEG_LIKELY 5'h02
`define SUB_NEG_LINK 5'h10
`define SUB_NEG_LINK_LIKELY 5'h12
`define LINK_REG 5'h1F
`define LINK_OFFSET 32'h00000008
`define SLOT_OFFSET 32'h00000004
`define IMM_SHIFT 2
`endif

// *** core/branch_target_calc.v ***
// Branch displacement and target address arithmetic
`timescale 1ns/1ps
`include "branch_decode_regs.vh"
module branch_target_calc #(
   parameter AW = 32
) (
   input wire [AW-1:0] i_pc,
   input wire [15:0] i_imm,
   output wire [AW-1:0] o_target,
   output wire [AW-1:0] o_link
);
   wire [17:0] disp18;
   wire [AW-1:0] disp;
   wire [AW-1:0] slot_pc;
   assign disp18 = {i_imm, 2'h0};
   assign disp = {{(AW-18){disp18[17]}}, disp18};
   assign slot_pc = i_pc + `SLOT_OFFSET;
   assign o_target = slot_pc + disp;
   assign o_link = i_pc + `LINK_OFFSET;
endmodule // branch_target_calc

// *** core/cond_branch_link_decode.v ***
// Decoder and executor for the negative and not-equal conditional branches
`timescale 1ns/1ps
`include "branch_decode_regs.vh"
module cond_branch_link_decode #(
   parameter AW = 32,
   parameter DW = 32
) (
   input wire i_clk,
   input wire i_reset,
   input wire i_valid,
   input wire [31:0] i_instr,
   input wire [AW-1:0] i_pc,
   input wire [DW-1:0] i_rs_data,
   input wire [DW-1:0] i_rt_data,
   output wire [4:0] o_rs_addr,
   output wire [4:0] o_rt_addr,
   output wire o_is_branch,
   output reg o_link_we,
   output reg [4:0] o_link_addr,
   output reg [DW-1:0] o_link_data,
   output reg o_redirect,
   output reg [AW-1:0] o_target,
   output reg o_nullify
);
   localparam ST_IDLE = 1'b0;
   localparam ST_SLOT = 1'b1;

   wire [5:0] opcode;
   wire [4:0] sub_op;
   wire [15:0] imm;
   wire op_reg_imm;
   wire branch_neg_link;
   wire branch_neg_link_likely;
   wire branch_neg_likely;
   wire branch_not_equal;
   wire branch_not_equal_likely;
   wire is_neg;
   wire is_likely;
   wire is_link;
   wire is_any;
   wire sign_set;
   wire regs_differ;
   wire cond;
   wire in_idle;
   wire in_slot;
   wire take;
   wire slot_seen;
   wire [AW-1:0] target;
   wire [AW-1:0] link;
   reg state_ff;
   reg nxt_state;
   reg cond_ff;
   reg nxt_cond;
   reg likely_ff;
   reg nxt_likely;
   reg [AW-1:0] target_ff;
   reg [AW-1:0] nxt_target;
   reg nxt_link_we;
   reg [DW-1:0] nxt_link_data;
   reg nxt_redirect;
   reg nxt_nullify;

   assign opcode = i_instr[`OP_HI:`OP_LO];
   assign sub_op = i_instr[`RT_HI:`RT_LO];
   assign imm = i_instr[`IMM_HI:`IMM_LO];
   assign o_rs_addr = i_instr[`RS_HI:`RS_LO];
   assign o_rt_addr = i_instr[`RT_HI:`RT_LO];

   assign op_reg_imm = (opcode == `OP_REG_IMMEDIATE);
   assign branch_neg_link = op_reg_imm
      && (sub_op == `SUB_NEG_LINK);
   assign branch_neg_link_likely = op_reg_imm
      && (sub_op == `SUB_NEG_LINK_LIKELY);
   assign branch_neg_likely = op_reg_imm
      && (sub_op == `SUB_NEG_LIKELY);
   assign branch_not_equal = (opcode == `OP_NOT_EQUAL);
   assign branch_not_equal_likely = (opcode == `OP_NOT_EQUAL_LIKELY);

   assign is_neg = branch_neg_link | branch_neg_link_likely | branch_neg_likely;
   assign is_link = branch_neg_link | branch_neg_link_likely;
   assign is_likely = branch_neg_link_likely | branch_neg_likely
      | branch_not_equal_likely;
   assign is_any = is_neg | branch_not_equal | branch_not_equal_likely;
   assign o_is_branch = i_valid & is_any;

   assign sign_set = i_rs_data[DW-1];
   assign regs_differ = (i_rs_data != i_rt_data);
   // Sign bit only; no full compare needed for a negative test
   assign cond = is_neg ? sign_set : regs_differ;

   assign in_idle = (state_ff == ST_IDLE);
   assign in_slot = (state_ff == ST_SLOT);
   // A branch in the slot is ignored rather than stacked; software must avoid it
   assign take = o_is_branch & in_idle;
   assign slot_seen = i_valid & in_slot;

   branch_target_calc #(
      .AW(AW)
   ) u_calc (
      .i_pc(i_pc),
      .i_imm(imm),
      .o_target(target),
      .o_link(link)
   );

   // The slot is the next issued instruction, however many idle cycles come first
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_state = ST_SLOT;
            end
         end
         ST_SLOT: begin
            if (i_valid) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @* begin
      nxt_cond = cond_ff;
      nxt_likely = likely_ff;
      nxt_target = target_ff;
      if (take) begin
         nxt_cond = cond;
         nxt_likely = is_likely;
         nxt_target = target;
      end
   end

   // Link is written even when not taken; rs of 31 would be clobbered
   always @* begin
      nxt_link_we = take & is_link;
      nxt_link_data = o_link_data;
      if (take) begin
         nxt_link_data = link[DW-1:0];
      end
   end

   always @* begin
      nxt_redirect = slot_seen & cond_ff;
      nxt_nullify = slot_seen & likely_ff & ~cond_ff;
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         cond_ff <= 1'b0;
      end else begin
         cond_ff <= nxt_cond;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         likely_ff <= 1'b0;
      end else begin
         likely_ff <= nxt_likely;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         target_ff <= {AW{1'b0}};
      end else begin
         target_ff <= nxt_target;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_link_we <= 1'b0;
         o_link_addr <= 5'h00;
         o_link_data <= {DW{1'b0}};
      end else begin
         o_link_we <= nxt_link_we;
         o_link_addr <= `LINK_REG;
         o_link_data <= nxt_link_data;
      end
   end

   // Slot cycle: redirect after slot, or squash slot for likely forms
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_redirect <= 1'b0;
         o_nullify <= 1'b0;
      end else begin
         o_redirect <= nxt_redirect;
         o_nullify <= nxt_nullify;
      end
   end

   // Target holds until the next slot, so a slow consumer still reads it
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_target <= {AW{1'b0}};
      end else if (slot_seen) begin
         o_target <= target_ff;
      end
   end
endmodule // cond_branch_link_decode

// *** sim/branch_chk.sv ***
// Port checks for the branch decoder
`timescale 1ns/1ps
module branch_chk (
   input wire i_clk, i_reset, i_valid, o_is_branch,
   input wire o_link_we, o_redirect, o_nullify,
   input wire [31:0] i_instr, i_pc, o_link_data,
   input wire [4:0] o_rs_addr, o_rt_addr, o_link_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   fld_a: assert property ({o_rs_addr, o_rt_addr} == i_instr[25:16])
      else $error("fields");
   ne_dec_a: assert property (i_valid && {i_instr[31], i_instr[29:26]} == 5'h05
      |-> o_is_branch) else $error("decode");
   link_reg_a: assert property (o_link_we |-> o_link_addr == 5'h1F)
      else $error("link reg");
   link_val_a: assert property (o_link_we |-> o_link_data == $past(i_pc) + 32'h8)
      else $error("link value");
   link_src_a: assert property (o_link_we |->
      ($past(i_instr[31:16]) & 16'hFC1D) == 16'h0410) else $error("link source");
   no_link_a: assert property (i_valid && i_instr[31:26] != 6'h01 |=> !o_link_we)
      else $error("stray link");
   one_way_a: assert property (!(o_redirect && o_nullify))
      else $error("both");
   slot_seen_a: assert property (o_redirect || o_nullify |-> $past(i_valid))
      else $error("no slot");
endmodule // branch_chk
bind cond_branch_link_decode branch_chk i_chk (
   .i_clk(i_clk),
   .i_reset(i_reset),
   .i_valid(i_valid),
   .o_is_branch(o_is_branch),
   .o_link_we(o_link_we),
   .o_redirect(o_redirect),
   .o_nullify(o_nullify),
   .i_instr(i_instr),
   .i_pc(i_pc),
   .o_link_data(o_link_data),
   .o_rs_addr(o_rs_addr),
   .o_rt_addr(o_rt_addr),
   .o_link_addr(o_link_addr)
);

// *** sim/tb_top.sv ***
// Directed bench for the branch decoder
`timescale 1ns/1ps
module tb_top;
   reg i_clk = 1'b0;
   reg i_reset = 1'b1;
   reg i_valid = 1'b0;
   reg [31:0] i_instr = 32'h00000000;
   reg [31:0] i_pc = 32'h00000000;
   reg [31:0] i_rs_data = 32'h00000000;
   reg [31:0] i_rt_data = 32'h00000000;
   wire o_is_branch;
   wire o_link_we;
   wire o_redirect;
   wire o_nullify;
   wire [31:0] o_link_data;
   wire [31:0] o_target;
   wire [4:0] o_rs_addr;
   wire [4:0] o_rt_addr;
   wire [4:0] o_link_addr;
   integer mismatches = 0;
   integer n_compared = 0;
   integer cyc = 0;

   cond_branch_link_decode i_dut (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_valid(i_valid),
      .i_instr(i_instr),
      .i_pc(i_pc),
      .i_rs_data(i_rs_data),
      .i_rt_data(i_rt_data),
      .o_rs_addr(o_rs_addr),
      .o_rt_addr(o_rt_addr),
      .o_is_branch(o_is_branch),
      .o_link_we(o_link_we),
      .o_link_addr(o_link_addr),
      .o_link_data(o_link_data),
      .o_redirect(o_redirect),
      .o_target(o_target),
      .o_nullify(o_nullify)
   );

   initial begin
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
   end
   // Tests need about 50 cycles, so 400 can only mean a hang
   initial begin
      wait (cyc == 400);
      mismatches = mismatches + 1;
      test_done;
   end

   task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
         end
      end
   endtask

   // Branch at 0x100, slot at 0x104 after gap idle cycles; x is link, redirect, nullify
   task br_slot(input [31:0] ins, input [31:0] rs, input [31:0] rt,
      input [1:0] gap, input [2:0] x);
      reg [31:0] t;
      begin
         t = 32'h00000104 + {{14{ins[15]}}, ins[15:0], 2'b00};
         @(posedge i_clk);
         i_valid <= 1'b1;
         i_instr <= ins;
         i_pc <= 32'h00000100;
         i_rs_data <= rs;
         i_rt_data <= rt;
         @(posedge i_clk);
         chk("branch", 32'h00000001, {31'h0, o_is_branch});
         chk("rs_addr", {27'h0, ins[25:21]}, {27'h0, o_rs_addr});
         chk("rt_addr", {27'h0, ins[20:16]}, {27'h0, o_rt_addr});
         i_valid <= (gap == 2'h0);
         i_instr <= 32'h00000000;
         i_pc <= 32'h00000104;
         #1 chk("link_we", {31'h0, x[2]}, {31'h0, o_link_we});
         if (x[2]) begin
            chk("link", 32'h00000108, o_link_data);
            chk("link_addr", 32'h0000001F, {27'h0, o_link_addr});
         end
         if (gap != 2'h0) begin
            repeat (gap) @(posedge i_clk);
            i_valid <= 1'b1;
         end
         @(posedge i_clk);
         i_valid <= 1'b0;
         #1 chk("redirect", {31'h0, x[1]}, {31'h0, o_redirect});
         chk("nullify", {31'h0, x[0]}, {31'h0, o_nullify});
         if (x[1]) begin
            chk("target", t, o_target);
         end
         @(posedge i_clk);
         #1 chk("pulse", 32'h00000000, {30'h0, o_redirect, o_nullify});
      end
   endtask

   // Source register field is 3 throughout, never the link register
   task test_link_likely;
      begin
         br_slot(32'h0472FFFF, 32'h80000000, 32'h0, 2'h0, 3'h6);
         br_slot(32'h04720010, 32'h7FFFFFFF, 32'h0, 2'h0, 3'h5);
         $display("done link likely");
      end
   endtask

   task test_neg_likely;
      begin
         br_slot(32'h04628000, 32'hFFFFFFFF, 32'h0, 2'h0, 3'h2);
         br_slot(32'h04620004, 32'h00000001, 32'h0, 2'h0, 3'h1);
         $display("done negative likely");
      end
   endtask

   task test_not_equal;
      begin
         br_slot(32'h14220004, 32'h5, 32'h6, 2'h2, 3'h2);
         br_slot(32'h14220004, 32'h5, 32'h5, 2'h0, 3'h0);
         $display("done not equal");
      end
   endtask

   task test_not_equal_likely;
      begin
         br_slot(32'h54227FFF, 32'h5, 32'h5, 2'h0, 3'h1);
         br_slot(32'h54227FFF, 32'h1, 32'h0, 2'h1, 3'h2);
         $display("done not equal likely");
      end
   endtask

   task test_link;
      begin
         br_slot(32'h04700002, 32'h80000000, 32'h0, 2'h0, 3'h6);
         br_slot(32'h04700002, 32'h00000001, 32'h0, 2'h0, 3'h4);
         $display("done link");
      end
   endtask

   task test_done;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask

   initial begin
      repeat (5) @(posedge i_clk);
      i_reset <= 1'b0;
      test_link_likely;
      test_neg_likely;
      test_not_equal;
      test_not_equal_likely;
      test_link;
      test_done;
   end
endmodule // tb_top
